// ---- hdl/sfep_pkg.sv ----
/*
   Shared constants and types for the serial flash erase, program and protect block.
   Assumes a single 50 MHz clock on both ends and a link clock made by the host end.
*/
// Overview of operation
// - C7 94 80 9A requests whole array erase.
// - Chip erase takes no address, extra bytes dropped.
// - Select release starts self-timed chip erase.
// - Busy reported throughout the chip erase.
// - Chip erase skips protected sectors.
// - Pin protection waits for running chip erase.
// - 264 mode: 82H, six/nine/nine address bits.
// - 256 mode: 82H, seven/nine/eight address bits.
// - Data fills buffer from offset, wraps.
// - Select rise erases page then writes buffer.
// - Busy during page erase and program.
// - 3D 2A 7F A9 enables software protection.
// - 3D 2A 7F 9A disables unless pin asserted.
// - Software protection comes up disabled.
// - Pin asserted blocks the disable command only, not enable.
// - Asserted pin enables protection within delay.
// - Pin release drops pin-only protection.
// - Software enable survives pin release.
// - Pin input is glitch filtered.
// - Status shows protection enabled.
// - Protected sectors come from protection register.
// - One byte per sector, sector 0 bit pairs.

package sfep_pkg;

   // =======================================================
   // Clock and timing
   localparam int CLK_PERIOD_NS              = 20;
   localparam int HALF_SCK_CYC               = 4;
   localparam int PIN_PROTECT_ENABLE_DELAY_NS  = 2000;
   localparam int PIN_PROTECT_DISABLE_DELAY_NS = 2000;
   localparam int PIN_ENABLE_CYC  = PIN_PROTECT_ENABLE_DELAY_NS / CLK_PERIOD_NS;
   localparam int PIN_DISABLE_CYC = PIN_PROTECT_DISABLE_DELAY_NS / CLK_PERIOD_NS;
   localparam int SYNC_LAT_CYC    = 4;
   localparam int WP_FILT_CYC     = ((PIN_ENABLE_CYC < PIN_DISABLE_CYC) ? PIN_ENABLE_CYC : PIN_DISABLE_CYC)
                                    - SYNC_LAT_CYC;

   // =======================================================
   // Command bytes
   localparam logic [31:0] SEQ_CHIP_ERASE = 32'hC794_809A;
   localparam logic [7:0]  OP_PROGRAM     = 8'h82;
   localparam logic [23:0] SEQ_PROT_HEAD  = 24'h3D_2A7F;
   localparam logic [7:0]  OP_PROT_EN     = 8'hA9;
   localparam logic [7:0]  OP_PROT_DIS    = 8'h9A;
   localparam int          HDR_BYTES      = 4;

   // =======================================================
   // Array geometry and protection layout
   localparam int          PAGES       = 512;
   localparam int          PAGE_FULL   = 264;
   localparam int          PAGE_BIN    = 256;
   localparam int          MEM_BYTES   = PAGES * PAGE_FULL;
   localparam logic [7:0]  ERASED      = 8'hFF;
   localparam logic [7:0]  SECT_PROT   = 8'hFF;
   localparam logic [8:0]  SEC0A_END   = 9'h008;
   localparam logic [8:0]  SEC0B_END   = 9'h080;
   localparam int          SEC0A_LSB   = 6;
   localparam int          SEC0B_LSB   = 4;

   // =======================================================
   // Reset values
   localparam logic [3:0]  LINK_IDLE   = 4'hA;
   localparam logic        SW_PROT_RST = 1'b0;

   // =======================================================
   // Types
   typedef enum logic [1:0] {CMD_CHIP_ERASE, CMD_PROGRAM, CMD_PROT_EN, CMD_PROT_DIS} sfep_cmd_t;
   typedef enum logic [1:0] {DS_IDLE, DS_CHIP, DS_PERASE, DS_PWRITE} sfep_dev_st_t;
   typedef enum logic [2:0] {HS_IDLE, HS_SHIFT, HS_FILL, HS_DESEL, HS_GAP} sfep_host_st_t;

endpackage : sfep_pkg

// ---- hdl/sfep_link_if.sv ----
/*
   Serial link between host end and device end.
   Assumes the host drives every wire; the device only listens.
*/
`timescale 1ns/1ps
`default_nettype none

interface sfep_link_if;
   logic sck;
   logic cs_n;
   logic si;
   logic wp_n;

   modport dev  (input  sck, cs_n, si, wp_n);
   modport host (output sck, cs_n, si, wp_n);
endinterface : sfep_link_if

`default_nettype wire

// ---- hdl/sfep_fifo.sv ----
/*
   Synchronous FIFO with valid and ready on both sides.
   Assumes one clock; ready and valid come from registers.
*/
`timescale 1ns/1ps
`default_nettype none

module sfep_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             arst_n_i,
   // Fill side
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  in_ready_o,
   // Drain side
   output logic                  out_valid_o,
   output logic      [WIDTH-1:0] out_data_o,
   input  wire logic             out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_m [0:DEPTH-1];
   logic [AW-1:0]    wr_r;
   logic [AW-1:0]    rd_r;
   logic [AW:0]      cnt_r;
   logic [AW:0]      cnt_nxt;
   logic             push;
   logic             pop;

   assign push       = in_valid_i & in_ready_o;
   assign pop        = out_valid_o & out_ready_i;
   assign cnt_nxt    = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
   assign out_data_o = mem_m[rd_r];

   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem_m[wr_r] <= in_data_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_r        <= '0;
         rd_r        <= '0;
         cnt_r       <= '0;
         in_ready_o  <= 1'b0;
         out_valid_o <= 1'b0;
      end else begin
         wr_r        <= push ? AW'((wr_r + 1'b1) % DEPTH) : wr_r;
         rd_r        <= pop ? AW'((rd_r + 1'b1) % DEPTH) : rd_r;
         cnt_r       <= cnt_nxt;
         in_ready_o  <= (cnt_nxt != (AW+1)'(DEPTH));
         out_valid_o <= (cnt_nxt != '0);
      end
   end
endmodule : sfep_fifo

`default_nettype wire

// ---- hdl/sfep_dev.sv ----
/*
   Device end: serial command decode, page buffer, main array model,
   self-timed erase and program engine, and sector protection.
   Assumes the link pins come from another clock domain and are sampled here.
*/
`timescale 1ns/1ps
`default_nettype none

module sfep_dev (
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        arst_n_i,
   // Serial link
   sfep_link_if.dev         link,
   // Configuration
   input  wire logic        page256_i,
   input  wire logic [31:0] prot_reg_i,
   // Array inspection
   input  wire logic [8:0]  rd_page_i,
   input  wire logic [8:0]  rd_col_i,
   output logic      [7:0]  rd_data_o,
   // Status
   output logic             busy_o,
   output logic             prot_en_o,
   output logic             spr_locked_o,
   output logic             reject_o
);

   // =======================================================
   // Pin sampling
   logic [3:0] raw;
   logic [3:0] s1_r;
   logic [3:0] s2_r;
   logic [3:0] s3_r;
   logic [3:0] lvl_r;
   logic [3:0] lvl_nxt;
   logic       sck_rise;
   logic       cs_fall;
   logic       cs_rise;
   logic       si_lvl;

   assign raw     = {link.wp_n, link.si, link.cs_n, link.sck};
   // A bit takes its new level only once the second and third stages agree.
   assign lvl_nxt = (s2_r & ~(s2_r ^ s3_r)) | (lvl_r & (s2_r ^ s3_r));
   assign sck_rise = lvl_nxt[0] & ~lvl_r[0] & ~lvl_nxt[1];
   assign cs_fall  = ~lvl_nxt[1] & lvl_r[1];
   assign cs_rise  = lvl_nxt[1] & ~lvl_r[1];
   assign si_lvl   = lvl_nxt[2];

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s1_r  <= sfep_pkg::LINK_IDLE;
         s2_r  <= sfep_pkg::LINK_IDLE;
         s3_r  <= sfep_pkg::LINK_IDLE;
         lvl_r <= sfep_pkg::LINK_IDLE;
      end else begin
         s1_r  <= raw;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         lvl_r <= lvl_nxt;
      end
   end

   // =======================================================
   // Protection state
   logic [6:0] wp_cnt_r;
   logic       wp_filt_r;
   logic       wp_eff_r;
   logic       sw_en_r;
   logic       prot_en;
   logic       wp_asserted;
   sfep_pkg::sfep_dev_st_t st_r;

   assign wp_asserted = ~lvl_r[3];
   assign prot_en     = sw_en_r | wp_eff_r;

   function automatic logic sect_prot(input logic [8:0] pg, input logic [31:0] pr);
      if (pg < sfep_pkg::SEC0A_END) begin
         return pr[sfep_pkg::SEC0A_LSB +: 2] == 2'b11;
      end else if (pg < sfep_pkg::SEC0B_END) begin
         return pr[sfep_pkg::SEC0B_LSB +: 2] == 2'b11;
      end else begin
         return pr[{pg[8:7], 3'b000} +: 8] == sfep_pkg::SECT_PROT;
      end
   endfunction : sect_prot

   // A pin change must persist for the filter time before it counts.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wp_cnt_r  <= '0;
         wp_filt_r <= 1'b0;
      end else if (wp_asserted != wp_filt_r) begin
         if (wp_cnt_r == 7'(sfep_pkg::WP_FILT_CYC - 1)) begin
            wp_cnt_r  <= '0;
            wp_filt_r <= wp_asserted;
         end else begin
            wp_cnt_r <= wp_cnt_r + 7'd1;
         end
      end else begin
         wp_cnt_r <= '0;
      end
   end

   // The pin level is frozen while a chip erase runs.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wp_eff_r <= 1'b0;
      end else if (st_r != sfep_pkg::DS_CHIP) begin
         wp_eff_r <= wp_filt_r;
      end
   end

   // =======================================================
   // Byte receiver
   logic [2:0]  bit_r;
   logic [2:0]  bidx_r;
   logic [7:0]  sh_r;
   logic [31:0] hdr_r;
   logic        rx_ok_r;
   logic [8:0]  ptr_r;
   logic [8:0]  pg_r;
   logic [7:0]  byte_v;
   logic        byte_done;
   logic [23:0] addr_v;
   logic [8:0]  plen;
   logic        is_prog;

   assign byte_v    = {sh_r[6:0], si_lvl};
   assign byte_done = sck_rise & (bit_r == 3'd7) & rx_ok_r;
   assign addr_v    = {hdr_r[15:0], byte_v};
   assign plen      = page256_i ? 9'(sfep_pkg::PAGE_BIN) : 9'(sfep_pkg::PAGE_FULL);
   assign is_prog   = hdr_r[31:24] == sfep_pkg::OP_PROGRAM;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         bit_r   <= '0;
         bidx_r  <= '0;
         sh_r    <= '0;
         hdr_r   <= '0;
         rx_ok_r <= 1'b0;
      end else if (cs_fall) begin
         bit_r   <= '0;
         bidx_r  <= '0;
         hdr_r   <= '0;
         rx_ok_r <= (st_r == sfep_pkg::DS_IDLE);
      end else if (sck_rise) begin
         bit_r <= bit_r + 3'd1;
         sh_r  <= byte_v;
         if (byte_done && bidx_r < 3'(sfep_pkg::HDR_BYTES)) begin
            hdr_r  <= {hdr_r[23:0], byte_v};
            bidx_r <= bidx_r + 3'd1;
         end
      end
   end

   logic [7:0] buf_m [0:sfep_pkg::PAGE_FULL-1];

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ptr_r <= '0;
         pg_r  <= '0;
      end else if (byte_done && bidx_r == 3'd3 && hdr_r[23:16] == sfep_pkg::OP_PROGRAM) begin
         pg_r  <= page256_i ? addr_v[16:8] : addr_v[17:9];
         ptr_r <= page256_i ? {1'b0, addr_v[7:0]} : addr_v[8:0];
      end else if (byte_done && bidx_r == 3'(sfep_pkg::HDR_BYTES) && is_prog) begin
         ptr_r <= (ptr_r == plen - 9'd1) ? 9'd0 : ptr_r + 9'd1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         buf_m <= '{default: sfep_pkg::ERASED};
      end else if (byte_done && bidx_r == 3'(sfep_pkg::HDR_BYTES) && is_prog && ptr_r < plen) begin
         buf_m[ptr_r] <= byte_v;
      end
   end

   // =======================================================
   // Command decode at select release
   logic cmd_end;
   logic go_chip;
   logic go_prog;
   logic prot_seq;

   assign cmd_end  = cs_rise & rx_ok_r & (bidx_r == 3'(sfep_pkg::HDR_BYTES));
   assign go_chip  = cmd_end & (hdr_r == sfep_pkg::SEQ_CHIP_ERASE);
   assign go_prog  = cmd_end & is_prog & ~(prot_en & sect_prot(pg_r, prot_reg_i));
   assign prot_seq = cmd_end & (hdr_r[31:8] == sfep_pkg::SEQ_PROT_HEAD);

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sw_en_r <= sfep_pkg::SW_PROT_RST;
      end else if (prot_seq && hdr_r[7:0] == sfep_pkg::OP_PROT_EN) begin
         sw_en_r <= 1'b1;
      end else if (prot_seq && hdr_r[7:0] == sfep_pkg::OP_PROT_DIS && !wp_eff_r) begin
         sw_en_r <= 1'b0;
      end
   end

   // Unknown protection tails and programs to protected sectors are refused here.
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reject_o <= 1'b0;
      end else begin
         reject_o <= (prot_seq && hdr_r[7:0] != sfep_pkg::OP_PROT_EN
                      && hdr_r[7:0] != sfep_pkg::OP_PROT_DIS)
                     || (cmd_end && is_prog && !go_prog);
      end
   end

   // =======================================================
   // Self-timed erase and program engine
   logic [8:0]  wpg_r;
   logic [8:0]  col_r;
   logic [17:0] waddr;
   logic        last_col;
   logic [7:0]  mem_m [0:sfep_pkg::MEM_BYTES-1];

   assign waddr    = {1'b0, wpg_r, 8'h00} + {6'h00, wpg_r, 3'b000} + {9'h000, col_r};
   assign last_col = col_r == 9'(sfep_pkg::PAGE_FULL - 1);

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_r   <= sfep_pkg::DS_IDLE;
         wpg_r  <= '0;
         col_r  <= '0;
         busy_o <= 1'b0;
      end else begin
         unique case (st_r)
            sfep_pkg::DS_IDLE: begin
               col_r <= '0;
               if (go_chip) begin
                  st_r   <= sfep_pkg::DS_CHIP;
                  wpg_r  <= '0;
                  busy_o <= 1'b1;
               end else if (go_prog) begin
                  st_r   <= sfep_pkg::DS_PERASE;
                  wpg_r  <= pg_r;
                  busy_o <= 1'b1;
               end
            end
            sfep_pkg::DS_CHIP: begin
               wpg_r <= wpg_r + 9'd1;
               if (wpg_r == 9'(sfep_pkg::PAGES - 1)) begin
                  st_r   <= sfep_pkg::DS_IDLE;
                  busy_o <= 1'b0;
               end
            end
            sfep_pkg::DS_PERASE: begin
               col_r <= last_col ? 9'd0 : col_r + 9'd1;
               if (last_col) begin
                  st_r <= sfep_pkg::DS_PWRITE;
               end
            end
            sfep_pkg::DS_PWRITE: begin
               col_r <= col_r + 9'd1;
               if (col_r == plen - 9'd1) begin
                  st_r   <= sfep_pkg::DS_IDLE;
                  busy_o <= 1'b0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (st_r == sfep_pkg::DS_CHIP && !(prot_en && sect_prot(wpg_r, prot_reg_i))) begin
         for (int c = 0; c < sfep_pkg::PAGE_FULL; c++) begin
            mem_m[waddr + 18'(c)] <= sfep_pkg::ERASED;
         end
      end else if (st_r == sfep_pkg::DS_PERASE) begin
         mem_m[waddr] <= sfep_pkg::ERASED;
      end else if (st_r == sfep_pkg::DS_PWRITE) begin
         mem_m[waddr] <= buf_m[col_r];
      end
      rd_data_o <= mem_m[{1'b0, rd_page_i, 8'h00} + {6'h00, rd_page_i, 3'b000} + {9'h000, rd_col_i}];
   end

   // =======================================================
   // Status outputs
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prot_en_o    <= 1'b0;
         spr_locked_o <= 1'b0;
      end else begin
         prot_en_o    <= prot_en;
         spr_locked_o <= wp_eff_r;
      end
   end

endmodule : sfep_dev

`default_nettype wire

// ---- hdl/sfep_host.sv ----
/*
   Host end: turns user commands into serial frames and feeds program data
   through a FIFO. Assumes the device samples the link on its own clock.
*/
`timescale 1ns/1ps
`default_nettype none

module sfep_host (
   // Clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              arst_n_i,
   // Serial link
   sfep_link_if.host              link,
   // Command port
   input  wire logic              cmd_valid_i,
   input  wire sfep_pkg::sfep_cmd_t cmd_i,
   input  wire logic [8:0]        page_i,
   input  wire logic [8:0]        offset_i,
   input  wire logic [8:0]        len_i,
   input  wire logic              page256_i,
   output logic                   cmd_ready_o,
   output logic                   done_o,
   // Program data
   input  wire logic              dat_valid_i,
   input  wire logic [7:0]        dat_i,
   output logic                   dat_ready_o,
   // Write protect request
   input  wire logic              wp_assert_i
);

   sfep_pkg::sfep_host_st_t st_r;
   logic [1:0]  div_r;
   logic        tick;
   logic [31:0] hdr_r;
   logic [31:0] hdr_v;
   logic [23:0] addr_v;
   logic [7:0]  sh_r;
   logic [2:0]  bit_r;
   logic [2:0]  hidx_r;
   logic [8:0]  left_r;
   logic        f_valid;
   logic [7:0]  f_data;
   logic        f_pop;

   // =======================================================
   // Data FIFO
   assign f_pop = (st_r == sfep_pkg::HS_FILL);

   sfep_fifo #(.WIDTH(8), .DEPTH(16)) u_fifo (
      .ref_clk_i   (ref_clk_i),
      .arst_n_i    (arst_n_i),
      .in_valid_i  (dat_valid_i),
      .in_data_i   (dat_i),
      .in_ready_o  (dat_ready_o),
      .out_valid_o (f_valid),
      .out_data_o  (f_data),
      .out_ready_i (f_pop)
   );

   // =======================================================
   // Frame building
   assign tick   = div_r == 2'(sfep_pkg::HALF_SCK_CYC - 1);
   assign addr_v = page256_i ? {7'h00, page_i, offset_i[7:0]} : {6'h00, page_i, offset_i};

   always_comb begin
      unique case (cmd_i)
         sfep_pkg::CMD_CHIP_ERASE: hdr_v = sfep_pkg::SEQ_CHIP_ERASE;
         sfep_pkg::CMD_PROGRAM:    hdr_v = {sfep_pkg::OP_PROGRAM, addr_v};
         sfep_pkg::CMD_PROT_EN:    hdr_v = {sfep_pkg::SEQ_PROT_HEAD, sfep_pkg::OP_PROT_EN};
         sfep_pkg::CMD_PROT_DIS:   hdr_v = {sfep_pkg::SEQ_PROT_HEAD, sfep_pkg::OP_PROT_DIS};
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_r <= '0;
      end else begin
         div_r <= tick ? 2'd0 : div_r + 2'd1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         link.wp_n <= 1'b1;
      end else begin
         link.wp_n <= ~wp_assert_i;
      end
   end

   // =======================================================
   // Link sequencer
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_r        <= sfep_pkg::HS_IDLE;
         hdr_r       <= '0;
         sh_r        <= '0;
         bit_r       <= '0;
         hidx_r      <= '0;
         left_r      <= '0;
         link.sck    <= 1'b0;
         link.cs_n   <= 1'b1;
         link.si     <= 1'b0;
         cmd_ready_o <= 1'b0;
         done_o      <= 1'b0;
      end else begin
         done_o <= 1'b0;
         unique case (st_r)
            sfep_pkg::HS_IDLE: begin
               cmd_ready_o <= 1'b1;
               if (cmd_valid_i && cmd_ready_o) begin
                  cmd_ready_o <= 1'b0;
                  link.cs_n   <= 1'b0;
                  link.si     <= hdr_v[31];
                  sh_r        <= hdr_v[31:24];
                  hdr_r       <= {hdr_v[23:0], 8'h00};
                  hidx_r      <= 3'd1;
                  bit_r       <= '0;
                  left_r      <= (cmd_i == sfep_pkg::CMD_PROGRAM) ? len_i : 9'd0;
                  st_r        <= sfep_pkg::HS_SHIFT;
               end
            end
            sfep_pkg::HS_SHIFT: begin
               if (tick && !link.sck) begin
                  link.sck <= 1'b1;
               end else if (tick) begin
                  link.sck <= 1'b0;
                  bit_r    <= bit_r + 3'd1;
                  sh_r     <= {sh_r[6:0], 1'b0};
                  link.si  <= sh_r[6];
                  if (bit_r == 3'd7 && hidx_r < 3'(sfep_pkg::HDR_BYTES)) begin
                     sh_r    <= hdr_r[31:24];
                     link.si <= hdr_r[31];
                     hdr_r   <= {hdr_r[23:0], 8'h00};
                     hidx_r  <= hidx_r + 3'd1;
                  end else if (bit_r == 3'd7) begin
                     st_r <= (left_r != 9'd0) ? sfep_pkg::HS_FILL : sfep_pkg::HS_DESEL;
                  end
               end
            end
            sfep_pkg::HS_FILL: begin
               if (f_valid) begin
                  sh_r    <= f_data;
                  link.si <= f_data[7];
                  left_r  <= left_r - 9'd1;
                  st_r    <= sfep_pkg::HS_SHIFT;
               end
            end
            sfep_pkg::HS_DESEL: begin
               if (tick) begin
                  link.cs_n <= 1'b1;
                  st_r      <= sfep_pkg::HS_GAP;
               end
            end
            sfep_pkg::HS_GAP: begin
               if (tick) begin
                  done_o <= 1'b1;
                  st_r   <= sfep_pkg::HS_IDLE;
               end
            end
            default: st_r <= sfep_pkg::HS_IDLE;
         endcase
      end
   end

endmodule : sfep_host

`default_nettype wire

// ---- verif/sfep_sva.sv ----
/* Checker for the serial link and the device status outputs.
   Assumes it is instantiated beside the link interface. */
`timescale 1ns/1ps
`default_nettype none
module sfep_sva (
   // Clock, reset, link and status
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic wp_n,
   input wire logic busy_o,
   input wire logic prot_en_o,
   input wire logic spr_locked_o,
   input wire logic reject_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence sck_high_s;
      sck [*4] ##1 !sck;
   endsequence
   sck_idle_a: assert property (cs_n |-> !sck) else $error("link clock runs while deselected");
   si_hold_a: assert property (sck |-> $stable(si)) else $error("data moved while clock high");
   sck_half_a: assert property ($rose(sck) |-> sck_high_s) else $error("clock high phase wrong");
   busy_min_a: assert property ($rose(busy_o) |-> busy_o [*8]) else $error("busy too short");
   busy_cause_a: assert property ($rose(busy_o) |-> $past(cs_n, 2)) else $error("busy before release");
   rej_pulse_a: assert property (reject_o |=> !reject_o) else $error("refusal not a pulse");
   wp_filter_a: assert property ($fell(wp_n) && !spr_locked_o |-> !spr_locked_o [*8])
      else $error("pin not filtered");
   pin_prot_a: assert property (spr_locked_o ##1 spr_locked_o |-> prot_en_o)
      else $error("pin lock without protection");
endmodule : sfep_sva
`default_nettype wire

// ---- verif/test_serial_flash_erase_program_protect.sv ----
/* Bench joining host and device ends over the link.
   Assumes the design files and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_erase_program_protect;
   logic                ref_clk_i = 0, arst_n_i = 0, cmd_valid_i = 0, dat_valid_i = 0, wp_assert_i = 0, page256_i = 0;
   logic                cmd_ready_o, done_o, dat_ready_o, busy_o, prot_en_o, spr_locked_o, reject_o;
   logic          [8:0] page_i = 0, offset_i = 0, len_i = 0, rd_page_i = 0, rd_col_i = 0;
   logic          [7:0] dat_i = 0, rd_data_o, exp_q[$];
   logic         [31:0] prot_reg_i = 0;
   sfep_pkg::sfep_cmd_t cmd_i = sfep_pkg::CMD_PROGRAM;
   integer              err_total = 0, n_compared = 0, cycles = 0, rej_cnt = 0, seed = 32'hd01f, i;
   sfep_link_if link ();
   sfep_host u_sfep_host (.ref_clk_i, .arst_n_i, .link(link.host), .cmd_valid_i, .cmd_i, .page_i, .offset_i,
      .len_i, .page256_i, .cmd_ready_o, .done_o, .dat_valid_i, .dat_i, .dat_ready_o, .wp_assert_i);
   sfep_dev u_sfep_dev (.ref_clk_i, .arst_n_i, .link(link.dev), .page256_i, .prot_reg_i, .rd_page_i,
      .rd_col_i, .rd_data_o, .busy_o, .prot_en_o, .spr_locked_o, .reject_o);
   sfep_sva u_sfep_sva (.ref_clk_i, .arst_n_i, .sck(link.sck), .cs_n(link.cs_n), .si(link.si),
      .wp_n(link.wp_n), .busy_o, .prot_en_o, .spr_locked_o, .reject_o);
   always #10 ref_clk_i = ~ref_clk_i;
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : close_out
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (reject_o === 1'b1) rej_cnt <= rej_cnt + 1;
      if (cycles == 20000) begin
         err_total = err_total + 1;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   function automatic logic [7:0] page_exp(input int k);
      return (k < 16) ? exp_q[k] : 8'hFF;
   endfunction : page_exp
   task automatic issue(input sfep_pkg::sfep_cmd_t c, input int pg, input int off, input int n);
      @(posedge ref_clk_i);
      cmd_i <= c;
      page_i <= 9'(pg);
      offset_i <= 9'(off);
      len_i <= 9'(n);
      cmd_valid_i <= 1'b1;
      do @(posedge ref_clk_i); while (cmd_ready_o !== 1'b1);
      cmd_valid_i <= 1'b0;
      do @(posedge ref_clk_i); while (done_o !== 1'b1);
      repeat (8) @(posedge ref_clk_i);
      do @(posedge ref_clk_i); while (busy_o !== 1'b0);
   endtask : issue
   task automatic push(input int n);
      for (i = 0; i < n; i++) begin
         dat_i <= 8'($random(seed));
         dat_valid_i <= 1'b1;
         do @(posedge ref_clk_i); while (dat_ready_o !== 1'b1);
         exp_q.push_back(dat_i);
      end
      dat_valid_i <= 1'b0;
   endtask : push
   task automatic rd(input int pg, input int col);
      rd_page_i <= 9'(pg);
      rd_col_i <= 9'(col);
      repeat (2) @(posedge ref_clk_i);
   endtask : rd
   initial begin
      repeat (16) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      @(posedge ref_clk_i);
      chk(prot_en_o, 0, "prot_en");
      push(16);
      @(posedge ref_clk_i);
      chk(dat_ready_o, 0, "fifo_ready");
      issue(sfep_pkg::CMD_PROGRAM, 37, 260, 16);
      for (i = 0; i < 17; i++) begin
         rd(37, (260 + i) % 264);
         chk(rd_data_o, page_exp(i), "page_byte");
      end
      prot_reg_i <= 32'h0000_0030;
      issue(sfep_pkg::CMD_PROT_EN, 0, 0, 0);
      chk(prot_en_o, 1, "prot_en");
      push(4);
      issue(sfep_pkg::CMD_PROGRAM, 37, 260, 4);
      chk(rej_cnt, 1, "reject");
      rd(37, 260);
      chk(rd_data_o, exp_q[0], "kept_byte");
      issue(sfep_pkg::CMD_PROT_DIS, 0, 0, 0);
      chk(prot_en_o, 0, "prot_en");
      wp_assert_i <= 1'b1;
      repeat (20) @(posedge ref_clk_i);
      wp_assert_i <= 1'b0;
      repeat (150) @(posedge ref_clk_i);
      chk(prot_en_o, 0, "prot_en");
      wp_assert_i <= 1'b1;
      repeat (150) @(posedge ref_clk_i);
      chk(prot_en_o, 1, "prot_en");
      issue(sfep_pkg::CMD_PROT_DIS, 0, 0, 0);
      chk(prot_en_o, 1, "prot_en");
      wp_assert_i <= 1'b0;
      repeat (150) @(posedge ref_clk_i);
      chk(prot_en_o, 0, "prot_en");
      wp_assert_i <= 1'b1;
      issue(sfep_pkg::CMD_PROT_EN, 0, 0, 0);
      wp_assert_i <= 1'b0;
      repeat (150) @(posedge ref_clk_i);
      chk(prot_en_o, 1, "prot_en");
      page256_i <= 1'b1;
      push(2);
      issue(sfep_pkg::CMD_PROGRAM, 300, 255, 2);
      rd(300, 255);
      chk(rd_data_o, exp_q[20], "page256_byte");
      rd(300, 0);
      chk(rd_data_o, exp_q[21], "page256_wrap");
      fork
         issue(sfep_pkg::CMD_CHIP_ERASE, 0, 0, 0);
         begin
            @(posedge ref_clk_i iff busy_o === 1'b1);
            wp_assert_i <= 1'b1;
            repeat (200) @(posedge ref_clk_i);
            chk(busy_o, 1, "chip_busy");
            chk(spr_locked_o, 0, "pin_deferred");
         end
      join
      repeat (2) @(posedge ref_clk_i);
      chk(spr_locked_o, 1, "pin_after_erase");
      wp_assert_i <= 1'b0;
      rd(37, 260);
      chk(rd_data_o, exp_q[0], "protected_kept");
      rd(300, 255);
      chk(rd_data_o, 8'hFF, "erased_byte");
      close_out();
   end
endmodule : test_serial_flash_erase_program_protect
`default_nettype wire
